// ### hw/cisp_map.svh
`ifndef CISP_MAP_SVH
`define CISP_MAP_SVH
`define CISP_FACTORY_P1      8'hFE
`define CISP_AUTOBAUD_SEL    8'hFF
`define CISP_NODE_ANY        8'hFF
`define CISP_IDENTIFIER_BASE_SEGMENT_MAX        8'h7F
`define CISP_IDENTIFIER_BASE_SEGMENT_RST        8'h00
`define CISP_NODE_RST        8'hFF
`define CISP_CFG_RST         8'hFF
`define CISP_BOOT_VER        8'h10
`define CISP_FUSE_BIT        6
`define CISP_NIB_SEL         4'h0
`define CISP_NIB_ERR         4'h6
`define CISP_SESS_OPEN       8'h01
`define CISP_SESS_CLOSED     8'h00
`define CISP_REG_CTRL        4'h0
`define CISP_REG_P1CF        4'h1
`define CISP_REG_P3CF        4'h2
`define CISP_REG_P4CF        4'h3
`define CISP_REG_ABSEL       4'h4
`define CISP_REG_BT1         4'h5
`define CISP_REG_BT2         4'h6
`define CISP_REG_BT3         4'h7
`define CISP_REG_NODE        4'h8
`define CISP_REG_IDENTIFIER_BASE_SEGMENT        4'h9
`define CISP_REG_STATUS      4'hA
`define CISP_REG_HWSEC       4'hB
`define CISP_REG_RXID        4'hC
`define CISP_REG_TIMING      4'hD
`endif

// ### hw/cisp_pkg.sv
package cisp_pkg;
  typedef enum logic [2:0] {
    CISP_SEL, CISP_PSTART, CISP_PDATA, CISP_DISP, CISP_WR, CISP_RD, CISP_ERR, CISP_NONE
  } cisp_cmd_e;
  typedef struct packed {
    logic [10:0] id;
    logic        ide;
    logic        rtr;
    logic [3:0]  dlc;
    logic [63:0] data;
  } cisp_frame_s;
  typedef struct packed {
    logic        ok;
    logic [2:0]  cmd;
  } cisp_dec_s;
endpackage

// ### hw/cisp_id_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "cisp_map.svh"
module cisp_id_decode
  import cisp_pkg::*;
(
  input  wire logic [10:0] ID,
  input  wire logic [6:0]  BASE,
  output cisp_dec_s        DEC
);
  always_comb begin
    DEC = '0;
    if (ID[10:4] == BASE && ID[3:0] <= `CISP_NIB_ERR) begin
      DEC.ok  = 1'b1;
      DEC.cmd = ID[2:0];
    end
  end
endmodule
`default_nettype wire

// ### hw/cisp_front_end.sv
// Overview of operation
// - Factory entry: loader starts when first port pins read FEh at reset.
// - User entry condition on port one, port three, or port four bits 0-1.
// - Loader restart allowed only while boot jump fuse is 0.
// - Only standard 11-bit data frames are exchanged; extended ignored.
// - Autobaud select FFh means autobaud; otherwise stored bit timing loads controller.
// - During autobaud, acknowledge withheld until timing is found.
// - Length code 0..8 data bytes; meaning set by identifier.
// - Identifier is base segment plus nibble 0h..6h command code.
// - Writing base segment relocates all command identifiers.
// - Base segment resets to 00h, accepts values up to 7Fh.
// - Error identifier is never transmitted by the device; one received from the host sets the error flag.
// - Node FFh accepted always; otherwise must match stored node number.
// - Accepted open/close answered length 2: version, then 01h open/00h closed.
// - Closed session ignores every command but open/close and the error identifier.
// - Entry condition honoured only while fuse bit 6 of security byte is 0.
`timescale 1ns/1ns
`default_nettype none
`include "cisp_map.svh"
module cisp_front_end
  import cisp_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  PORT1_PINS,
  input  wire logic [7:0]  PORT3_PINS,
  input  wire logic [1:0]  PORT4_PINS,
  input  wire logic [7:0]  HW_SECURITY,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        RX_VALID,
  input  wire cisp_frame_s RX_FRAME,
  input  wire logic        TIMING_FOUND,
  output logic             TX_VALID,
  output cisp_frame_s      TX_FRAME,
  input  wire logic        TX_READY,
  output logic             RX_ACK_EN,
  output logic [23:0]      BIT_TIMING,
  output logic             AUTOBAUD,
  output logic             CMD_VALID,
  output cisp_frame_s      CMD_FRAME,
  output logic             LOADER_RUN
);
  typedef enum logic [1:0] {ST_ENTRY, ST_IDLE, ST_REPLY} cisp_state_e;
  typedef struct packed {
    cisp_state_e st;
    logic        run;
    logic        open;
    logic        baud_ok;
    logic [7:0]  p1cf, p3cf, p4cf, absel, bt1, bt2, bt3, node;
    logic [6:0]  identifier_base_segment;
    logic        tx_v;
    cisp_frame_s tx;
    logic        cmd_v;
    cisp_frame_s cmd;
    logic [31:0] rdata;
    logic        wait_n;
    logic [10:0] last_id;
    logic        err_flag;
  } cisp_st_s;
  cisp_st_s  r, next_r;
  cisp_dec_s dec;
  logic      entry_hit;
  logic [7:0] wb;
  logic       err_set;

  cisp_id_decode u_dec (
    .ID   (RX_FRAME.id),
    .BASE (r.identifier_base_segment),
    .DEC  (dec)
  );

  always_comb begin
    entry_hit = 1'b0;
    if (r.p1cf != `CISP_CFG_RST)
      entry_hit = (PORT1_PINS == r.p1cf);
    else if (r.p3cf != `CISP_CFG_RST)
      entry_hit = (PORT3_PINS == r.p3cf);
    else if (r.p4cf != `CISP_CFG_RST)
      entry_hit = (PORT4_PINS == r.p4cf[1:0]);
    else
      entry_hit = (PORT1_PINS == `CISP_FACTORY_P1);
  end

  always_comb begin
    next_r        = r;
    next_r.cmd_v  = 1'b0;
    next_r.wait_n = 1'b0;
    wb            = AVS_WRITEDATA[7:0];
    err_set       = 1'b0;
    case (r.st)
      ST_ENTRY: begin
        next_r.run = entry_hit && !HW_SECURITY[`CISP_FUSE_BIT];
        next_r.st  = ST_IDLE;
      end
      ST_IDLE: begin
        if (TIMING_FOUND)
          next_r.baud_ok = 1'b1;
        if (r.run && RX_VALID && !RX_FRAME.ide && !RX_FRAME.rtr
            && RX_FRAME.dlc <= 4'h8 && dec.ok) begin
          next_r.last_id = RX_FRAME.id;
          if (dec.cmd == CISP_SEL) begin
            if (RX_FRAME.dlc == 4'h1 && (RX_FRAME.data[63:56] == `CISP_NODE_ANY
                || RX_FRAME.data[63:56] == r.node)) begin
              next_r.open    = !r.open;
              next_r.tx      = '0;
              next_r.tx.id   = {r.identifier_base_segment, `CISP_NIB_SEL};
              next_r.tx.dlc  = 4'h2;
              next_r.tx.data[63:56] = `CISP_BOOT_VER;
              next_r.tx.data[55:48] = r.open ? `CISP_SESS_CLOSED : `CISP_SESS_OPEN;
              next_r.tx_v    = 1'b1;
              next_r.st      = ST_REPLY;
            end
          end else if (dec.cmd == CISP_ERR) begin
            next_r.err_flag = 1'b1;
            err_set         = 1'b1;
          end else if (r.open) begin
            next_r.cmd_v = 1'b1;
            next_r.cmd   = RX_FRAME;
          end
        end
      end
      ST_REPLY: begin
        if (TX_READY) begin
          next_r.tx_v = 1'b0;
          next_r.st   = ST_IDLE;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
    if ((AVS_READ || AVS_WRITE) && !r.wait_n) begin
      next_r.wait_n = 1'b1;
      next_r.rdata  = '0;
    end
    // Writes land on the edge at which the master sees waitrequest low
    if (AVS_READ || AVS_WRITE) begin
      if (AVS_WRITE && r.wait_n && AVS_BYTEENABLE[0]) begin
        case (AVS_ADDRESS)
          `CISP_REG_CTRL: begin
            if (wb[0] && r.st == ST_IDLE) begin
              next_r.st   = ST_ENTRY;
              next_r.tx_v = 1'b0;
              next_r.open = 1'b0;
            end
          end
          `CISP_REG_P1CF:  next_r.p1cf  = wb;
          `CISP_REG_P3CF:  next_r.p3cf  = wb;
          `CISP_REG_P4CF:  next_r.p4cf  = wb;
          `CISP_REG_ABSEL: next_r.absel = wb;
          `CISP_REG_BT1:   next_r.bt1   = wb;
          `CISP_REG_BT2:   next_r.bt2   = wb;
          `CISP_REG_BT3:   next_r.bt3   = wb;
          `CISP_REG_NODE:  next_r.node  = wb;
          `CISP_REG_IDENTIFIER_BASE_SEGMENT: begin
            if (wb <= `CISP_IDENTIFIER_BASE_SEGMENT_MAX)
              next_r.identifier_base_segment = wb[6:0];
          end
          `CISP_REG_STATUS: if (wb[3] && !err_set) next_r.err_flag = 1'b0;
          default: next_r.rdata = '0;
        endcase
      end else if (AVS_READ && !r.wait_n) begin
        case (AVS_ADDRESS)
          `CISP_REG_P1CF:   next_r.rdata = {24'h000000, r.p1cf};
          `CISP_REG_P3CF:   next_r.rdata = {24'h000000, r.p3cf};
          `CISP_REG_P4CF:   next_r.rdata = {24'h000000, r.p4cf};
          `CISP_REG_ABSEL:  next_r.rdata = {24'h000000, r.absel};
          `CISP_REG_BT1:    next_r.rdata = {24'h000000, r.bt1};
          `CISP_REG_BT2:    next_r.rdata = {24'h000000, r.bt2};
          `CISP_REG_BT3:    next_r.rdata = {24'h000000, r.bt3};
          `CISP_REG_NODE:   next_r.rdata = {24'h000000, r.node};
          `CISP_REG_IDENTIFIER_BASE_SEGMENT:   next_r.rdata = {25'h0, r.identifier_base_segment};
          `CISP_REG_STATUS: next_r.rdata = {28'h0000000, r.err_flag, r.baud_ok, r.open, r.run};
          `CISP_REG_HWSEC:  next_r.rdata = {24'h000000, HW_SECURITY};
          `CISP_REG_RXID:   next_r.rdata = {21'h0, r.last_id};
          default:          next_r.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      r       <= '0;
      r.st    <= ST_ENTRY;
      r.p1cf  <= `CISP_FACTORY_P1;
      r.p3cf  <= `CISP_CFG_RST;
      r.p4cf  <= `CISP_CFG_RST;
      r.absel <= `CISP_CFG_RST;
      r.bt1   <= `CISP_CFG_RST;
      r.bt2   <= `CISP_CFG_RST;
      r.bt3   <= `CISP_CFG_RST;
      r.node  <= `CISP_NODE_RST;
      r.identifier_base_segment  <= 7'h00;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    AVS_READDATA    = r.rdata;
    AVS_WAITREQUEST = !r.wait_n;
    TX_VALID        = r.tx_v;
    TX_FRAME        = r.tx;
    CMD_VALID       = r.cmd_v;
    CMD_FRAME       = r.cmd;
    LOADER_RUN      = r.run;
    AUTOBAUD        = (r.absel == `CISP_AUTOBAUD_SEL);
    BIT_TIMING      = {r.bt1, r.bt2, r.bt3};
    RX_ACK_EN       = r.run && (!AUTOBAUD || r.baud_ok);
  end

  chk_reply_len: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    TX_VALID |-> TX_FRAME.dlc == 4'h2 && TX_FRAME.data[63:56] == `CISP_BOOT_VER)
    else $error("open/close reply malformed");
  chk_reply_state: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $rose(TX_VALID) |-> TX_FRAME.data[48] == r.open) else $error("reply state byte wrong");
  chk_closed_quiet: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CMD_VALID |-> $past(r.open)) else $error("command passed while closed");
  chk_identifier_base_segment_limit: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    r.identifier_base_segment <= 7'h7F) else $error("base segment out of range");
  chk_ack_hold: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (AUTOBAUD && !r.baud_ok) |-> !RX_ACK_EN) else $error("ack before timing found");
  chk_fuse_block: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $rose(LOADER_RUN) |-> !$past(HW_SECURITY[6])) else $error("loader started with fuse set");
  chk_no_ext: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (RX_VALID && RX_FRAME.ide) |=> !CMD_VALID && !$rose(TX_VALID)) else $error("extended frame used");
  chk_no_err_tx: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    $rose(TX_VALID) |-> TX_FRAME.id[3:0] == 4'h0) else $error("wrong reply identifier");
  chk_mismatch: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (r.st == ST_IDLE && RX_VALID && dec.ok && dec.cmd == CISP_SEL && RX_FRAME.data[63:56] != 8'hFF
     && RX_FRAME.data[63:56] != r.node) |=> $stable(r.open)) else $error("session changed on mismatch");

  // Several-step behaviours are built from these
  sequence s_bus_take;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_base_write;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == `CISP_REG_IDENTIFIER_BASE_SEGMENT;
  endsequence
  sequence s_rx_std;
    r.st == ST_IDLE && r.run && RX_VALID && !RX_FRAME.ide && !RX_FRAME.rtr && dec.ok;
  endsequence
  sequence s_select;
    RX_FRAME.dlc == 4'h1 && dec.cmd == CISP_SEL;
  endsequence

  chk_bus_answer: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_bus_take |=> !AVS_WAITREQUEST) else $error("bus request not answered");
  chk_bus_single: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("bus answer held too long");
  chk_base_move: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_base_write ##0 (AVS_WRITEDATA[7:0] <= `CISP_IDENTIFIER_BASE_SEGMENT_MAX) |=> r.identifier_base_segment == $past(AVS_WRITEDATA[6:0]))
    else $error("base segment not relocated");
  chk_base_refuse: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_base_write ##0 (AVS_WRITEDATA[7:0] > `CISP_IDENTIFIER_BASE_SEGMENT_MAX) |=> $stable(r.identifier_base_segment))
    else $error("base segment took too large a value");
  chk_open_any: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_rx_std ##0 s_select ##0 (RX_FRAME.data[63:56] == `CISP_NODE_ANY) |=> TX_VALID && r.open != $past(r.open))
    else $error("broadcast select not accepted");
  chk_open_node: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_rx_std ##0 s_select ##0 (RX_FRAME.data[63:56] == r.node) |=> TX_VALID)
    else $error("own node select not accepted");
  chk_quiet_node: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_rx_std ##0 s_select ##0 (RX_FRAME.data[63:56] != `CISP_NODE_ANY && RX_FRAME.data[63:56] != r.node)
    |=> !$rose(TX_VALID)) else $error("reply to foreign node");
  chk_cmd_pass: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_rx_std ##0 (r.open && RX_FRAME.dlc <= 4'h8 && dec.cmd != CISP_SEL && dec.cmd != CISP_ERR)
    |=> CMD_VALID && CMD_FRAME == $past(RX_FRAME)) else $error("open session dropped a command");
  chk_long_dlc: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (RX_VALID && RX_FRAME.dlc > 4'h8) |=> !CMD_VALID && !$rose(TX_VALID)) else $error("bad length used");
  chk_rtr_drop: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (RX_VALID && RX_FRAME.rtr) |=> !CMD_VALID && !$rose(TX_VALID)) else $error("remote frame used");
  chk_err_latch: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_rx_std ##0 (RX_FRAME.dlc <= 4'h8 && dec.cmd == CISP_ERR) |=> r.err_flag)
    else $error("host error frame not flagged");
  chk_entry_factory: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (r.st == ST_ENTRY && r.p1cf == `CISP_FACTORY_P1 && PORT1_PINS == `CISP_FACTORY_P1
     && !HW_SECURITY[`CISP_FUSE_BIT]) |=> LOADER_RUN) else $error("factory entry missed");
  chk_entry_user: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (r.st == ST_ENTRY && r.p1cf == `CISP_CFG_RST && r.p3cf != `CISP_CFG_RST && PORT3_PINS == r.p3cf
     && !HW_SECURITY[`CISP_FUSE_BIT]) |=> LOADER_RUN) else $error("user entry missed");
  chk_fuse_off: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (r.st == ST_ENTRY && HW_SECURITY[`CISP_FUSE_BIT]) |=> !LOADER_RUN) else $error("entry with fuse set");
  chk_run_hold: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    (r.st != ST_ENTRY) |=> $stable(LOADER_RUN)) else $error("loader state moved outside entry");
  chk_baud_sticky: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    r.baud_ok |=> r.baud_ok) else $error("found timing forgotten");
endmodule
`default_nettype wire

// ### bench/cisp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module cisp_host_model
  import cisp_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RX_ACK_EN,
  input  wire logic        TX_VALID,
  input  wire cisp_frame_s TX_FRAME,
  output logic             TX_READY,
  output logic             RX_VALID,
  output cisp_frame_s      RX_FRAME
);
  integer      seed = 99;
  int          n_tx = 0;
  cisp_frame_s got;

  initial begin
    TX_READY = 1'b0;
    RX_VALID = 1'b0;
    RX_FRAME = '0;
  end

  // Replies are taken after a random stall, prompt or slow
  always @(posedge CLOCK) begin
    TX_READY <= 1'($random(seed));
    if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
      got <= TX_FRAME;
      n_tx <= n_tx + 1;
    end
  end

  // One frame, repeated until the receiver acknowledges; idle lines keep moving
  task automatic send(input cisp_frame_s f);
    do begin
      @(posedge CLOCK);
      RX_FRAME <= f;
      RX_VALID <= 1'b1;
      @(posedge CLOCK);
      RX_VALID <= 1'b0;
      RX_FRAME <= ~f;
    end while (RX_ACK_EN !== 1'b1);
  endtask
endmodule
`default_nettype wire

// ### bench/tb_cisp_front_end.sv
`timescale 1ns/1ns
`default_nettype none
`include "cisp_map.svh"
module tb_cisp_front_end
  import cisp_pkg::*;
;
  logic        CLOCK = 1'b0;
  logic        ARST_N = 1'b0;
  logic [7:0]  PORT1_PINS = 8'hFE;
  logic [7:0]  PORT3_PINS = 8'h00;
  logic [1:0]  PORT4_PINS = 2'h0;
  logic [7:0]  HW_SECURITY = 8'h00;
  logic [3:0]  AVS_ADDRESS = 4'h0;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0]  AVS_BYTEENABLE = 4'hF;
  logic        TIMING_FOUND = 1'b0;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST, RX_VALID, TX_VALID, TX_READY, RX_ACK_EN;
  logic        AUTOBAUD, CMD_VALID, LOADER_RUN;
  logic [23:0] BIT_TIMING;
  cisp_frame_s RX_FRAME, TX_FRAME, CMD_FRAME, cmd_q, f;
  integer      seed = 47;
  int          n_fail = 0, tests_run = 0, n_cmd = 0, n0;
  logic [6:0]  base = 7'h00;
  logic [7:0]  node;
  logic [31:0] q, w;

  cisp_front_end i_cisp_front_end (.*);
  cisp_host_model i_cisp_host_model (.*);

  initial forever #4 CLOCK = ~CLOCK;

  always @(posedge CLOCK) if (CMD_VALID === 1'b1) begin
    cmd_q <= CMD_FRAME;
    n_cmd <= n_cmd + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  function automatic logic [31:0] pk(input cisp_frame_s x);
    return {1'b0, x.id, x.dlc, x.data[63:48]};
  endfunction

  function automatic cisp_frame_s mk(input logic [3:0] nib, input logic [3:0] n, input logic [63:0] d);
    return '{id: {base, nib}, ide: 1'b0, rtr: 1'b0, dlc: n, data: d};
  endfunction

  // Open/close request; want is the expected session byte, or -1 for silence
  task automatic sel(input logic [7:0] nd, input int want);
    n0 = i_cisp_host_model.n_tx;
    i_cisp_host_model.send(mk(`CISP_NIB_SEL, 4'h1, {nd, 56'h0}));
    repeat (20) @(posedge CLOCK);
    chk(i_cisp_host_model.n_tx - n0, (want < 0) ? 0 : 1);
    if (want >= 0) chk(pk(i_cisp_host_model.got), {1'b0, base, 4'h0, 4'h2, `CISP_BOOT_VER, 8'(want)});
  endtask

  task automatic cmd(input logic [3:0] nib, input logic ext, input int want);
    f = mk(nib, 4'($unsigned($random(seed)) % 9), {$random(seed), $random(seed)});
    f.ide = ext;
    n0 = n_cmd;
    i_cisp_host_model.send(f);
    repeat (4) @(posedge CLOCK);
    chk(n_cmd - n0, want);
    if (want > 0) chk(pk(cmd_q), pk(f));
  endtask

  initial begin
    PORT3_PINS <= 8'($random(seed));
    PORT4_PINS <= 2'($random(seed));
    repeat (20) @(posedge CLOCK);
    ARST_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    chk(LOADER_RUN, 1);
    chk(AUTOBAUD, 1);
    chk(RX_ACK_EN, 0);
    TIMING_FOUND <= 1'b1;
    @(posedge CLOCK);
    TIMING_FOUND <= 1'b0;
    repeat (2) @(posedge CLOCK);
    chk(RX_ACK_EN, 1);
    av(0, `CISP_REG_IDENTIFIER_BASE_SEGMENT, 0);
    chk(q, 0);
    av(0, 4'hF, 0);
    chk(q, 0);
    cmd(4'h2, 0, 0);
    for (int k = 0; k < 3; k++) begin
      w = (k == 0) ? 32'h7F : 32'($random(seed)) & 32'h7F;
      av(1, `CISP_REG_IDENTIFIER_BASE_SEGMENT, w);
      av(1, `CISP_REG_IDENTIFIER_BASE_SEGMENT, w | 32'h80);
      av(0, `CISP_REG_IDENTIFIER_BASE_SEGMENT, 0);
      chk(q, w);
      base = w[6:0];
      node = 8'($random(seed)) & 8'h7F;
      av(1, `CISP_REG_NODE, node);
      sel(8'hFF, 1);
      av(0, `CISP_REG_STATUS, 0);
      chk(q, 32'h7);
      for (int n = 1; n < 6; n++) cmd(4'(n), 0, 1);
      cmd(4'h3, 1, 0);
      base ^= 7'h01;
      cmd(4'h1, 0, 0);
      base ^= 7'h01;
      sel(node ^ 8'h01, -1);
      sel(node, 0);
      cmd(4'h5, 0, 0);
    end
    w = $random(seed);
    av(1, `CISP_REG_BT1, w[23:16]);
    av(1, `CISP_REG_BT2, w[15:8]);
    av(1, `CISP_REG_BT3, w[7:0]);
    av(1, `CISP_REG_ABSEL, 0);
    repeat (2) @(posedge CLOCK);
    chk(AUTOBAUD, 0);
    chk(BIT_TIMING, w[23:0]);
    for (int k = 0; k < 2; k++) begin
      ARST_N <= 1'b0;
      HW_SECURITY <= k ? 8'h40 : 8'hBF;
      PORT1_PINS <= k ? 8'hFE : 8'hFC;
      repeat (3) @(posedge CLOCK);
      ARST_N <= 1'b1;
      repeat (2) @(posedge CLOCK);
      chk(LOADER_RUN, 0);
    end
    HW_SECURITY <= 8'h00;
    PORT3_PINS <= 8'h5A;
    PORT4_PINS <= 2'h1;
    av(1, `CISP_REG_P1CF, 32'hFF);
    av(1, `CISP_REG_P3CF, 32'h5A);
    av(1, `CISP_REG_CTRL, 32'h1);
    repeat (2) @(posedge CLOCK);
    chk(LOADER_RUN, 1);
    av(1, `CISP_REG_P3CF, 32'hFF);
    av(1, `CISP_REG_P4CF, 32'h2);
    av(1, `CISP_REG_CTRL, 32'h1);
    repeat (2) @(posedge CLOCK);
    chk(LOADER_RUN, 0);
    conclude();
  end

  initial begin
    #400000;
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
